/* File: tap_pkg.sv */
// constants and carrier types for the boundary-scan test port
package tap_pkg;

   // tap controller states
   typedef enum logic [3:0] {
      st_reset, st_idle,
      st_sel_dr, st_cap_dr, st_shift_dr, st_ex1_dr, st_pause_dr, st_ex2_dr, st_upd_dr,
      st_sel_ir, st_cap_ir, st_shift_ir, st_ex1_ir, st_pause_ir, st_ex2_ir, st_upd_ir
   } tap_state_t;

   // instruction register layout
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h3;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;

   // identification register, value arbitrary
   localparam logic [31:0] IDCODE_VALUE = 32'h0000_0001;
   localparam int ID_W = 32;

   // boundary register length, arbitrary default
   localparam int BSR_W = 8;

   // sampled link pins after synchronisation
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } link_t;

   // derived test-clock events
   typedef struct packed {
      logic rise;
      logic fall;
   } tck_edge_t;

endpackage : tap_pkg

/* File: sync2.sv */
// two-flop synchroniser for one pin
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // pin in, synchronised out
   input wire logic i_async,
   output logic o_sync
);
   logic meta;
   logic next_meta;
   logic next_sync;

   // first stage feeds only the second
   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule : sync2
`default_nettype wire

/* File: boundary_scan_test_port.sv */
// boundary-scan test access port, oversampled from the system clock
// What this block does
// - serial test data is launched onto the data output at a falling test-clock edge.
// - the data output floats unless a shift of instruction or data is in progress.
// - a low test reset forces the controller to test-logic-reset without a test-clock edge.
// - serial instructions and data on the data input shift into the selected register.
// - the controller state advances from the mode-select level at each rising test-clock edge.
// - all test logic advances only on test-clock events, apart from test reset.
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_test_port
   import tap_pkg::*;
(
   // system clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // test link pins
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   input wire logic i_trst_n,
   output logic o_tdo,
   output logic o_tdo_oe_n,
   // boundary cell capture and update
   input wire logic [BSR_W-1:0] i_pins,
   output logic [BSR_W-1:0] o_pins,
   output logic o_extest
);

   ////////////////////////////////////////////////////////////////////
   link_t lnk;
   tck_edge_t edge_ev;
   logic tck_d;
   logic next_tck_d;

   // every test link pin passes two flops before use; boundary inputs i_pins are used directly
   sync2 #(.RST_VAL(1'b0)) u_tck (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_tck),
      .o_sync(lnk.tck));
   sync2 #(.RST_VAL(1'b1)) u_tms (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_tms),
      .o_sync(lnk.tms));
   sync2 #(.RST_VAL(1'b1)) u_tdi (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_tdi),
      .o_sync(lnk.tdi));
   sync2 #(.RST_VAL(1'b0)) u_trst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_trst_n),
      .o_sync(lnk.trst_n));

   // edge detection on the synchronised test clock
   always_comb begin
      next_tck_d = lnk.tck;
      edge_ev.rise = lnk.tck & ~tck_d;
      edge_ev.fall = ~lnk.tck & tck_d;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= next_tck_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   tap_state_t state;
   tap_state_t next_state;

   // controller walk; test reset wins without waiting for a clock event
   always_comb begin
      next_state = state;
      if (!lnk.trst_n) begin
         next_state = st_reset;
      end else if (edge_ev.rise) begin
         unique case (state)
            st_reset: next_state = lnk.tms ? st_reset : st_idle;
            st_idle: next_state = lnk.tms ? st_sel_dr : st_idle;
            st_sel_dr: next_state = lnk.tms ? st_sel_ir : st_cap_dr;
            st_cap_dr: next_state = lnk.tms ? st_ex1_dr : st_shift_dr;
            st_shift_dr: next_state = lnk.tms ? st_ex1_dr : st_shift_dr;
            st_ex1_dr: next_state = lnk.tms ? st_upd_dr : st_pause_dr;
            st_pause_dr: next_state = lnk.tms ? st_ex2_dr : st_pause_dr;
            st_ex2_dr: next_state = lnk.tms ? st_upd_dr : st_shift_dr;
            st_upd_dr: next_state = lnk.tms ? st_sel_dr : st_idle;
            st_sel_ir: next_state = lnk.tms ? st_reset : st_cap_ir;
            st_cap_ir: next_state = lnk.tms ? st_ex1_ir : st_shift_ir;
            st_shift_ir: next_state = lnk.tms ? st_ex1_ir : st_shift_ir;
            st_ex1_ir: next_state = lnk.tms ? st_upd_ir : st_pause_ir;
            st_pause_ir: next_state = lnk.tms ? st_ex2_ir : st_pause_ir;
            st_ex2_ir: next_state = lnk.tms ? st_upd_ir : st_shift_ir;
            st_upd_ir: next_state = lnk.tms ? st_sel_dr : st_idle;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= st_reset;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [IR_W-1:0] ir_sh;
   logic [IR_W-1:0] ir;
   logic [ID_W-1:0] id_sh;
   logic [BSR_W-1:0] bsr_sh;
   logic byp;
   logic [IR_W-1:0] next_ir_sh;
   logic [IR_W-1:0] next_ir;
   logic [ID_W-1:0] next_id_sh;
   logic [BSR_W-1:0] next_bsr_sh;
   logic next_byp;
   logic [BSR_W-1:0] next_pins;
   logic next_extest;
   logic bsr_sel;

   // capture, shift and update on rising test-clock events only
   always_comb begin
      next_ir_sh = ir_sh;
      next_ir = ir;
      next_id_sh = id_sh;
      next_bsr_sh = bsr_sh;
      next_byp = byp;
      next_pins = o_pins;
      bsr_sel = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
      if (!lnk.trst_n || state == st_reset) begin
         next_ir = IR_IDCODE;
      end else if (edge_ev.rise) begin
         unique case (state)
            st_cap_ir: next_ir_sh = IR_CAPTURE;
            st_shift_ir: next_ir_sh = {lnk.tdi, ir_sh[IR_W-1:1]};
            st_upd_ir: next_ir = ir_sh;
            st_cap_dr: begin
               next_id_sh = IDCODE_VALUE;
               next_bsr_sh = i_pins;
               next_byp = 1'b0;
            end
            st_shift_dr: begin
               if (ir == IR_IDCODE) begin
                  next_id_sh = {lnk.tdi, id_sh[ID_W-1:1]};
               end else if (bsr_sel) begin
                  next_bsr_sh = {lnk.tdi, bsr_sh[BSR_W-1:1]};
               end else begin
                  next_byp = lnk.tdi;
               end
            end
            st_upd_dr: begin
               if (bsr_sel) begin
                  next_pins = bsr_sh;
               end
            end
            default: ;
         endcase
      end
      next_extest = (ir == IR_EXTEST);
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ir_sh <= '0;
         ir <= IR_IDCODE;
         id_sh <= '0;
         bsr_sh <= '0;
         byp <= 1'b0;
         o_pins <= '0;
         o_extest <= 1'b0;
      end else begin
         ir_sh <= next_ir_sh;
         ir <= next_ir;
         id_sh <= next_id_sh;
         bsr_sh <= next_bsr_sh;
         byp <= next_byp;
         o_pins <= next_pins;
         o_extest <= next_extest;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic next_tdo;
   logic next_tdo_oe_n;

   // output changes only at falling events or on test reset, so the tester samples a stable bit
   always_comb begin
      next_tdo = o_tdo;
      next_tdo_oe_n = o_tdo_oe_n;
      if (!lnk.trst_n) begin
         next_tdo_oe_n = 1'b1;
      end else if (edge_ev.fall) begin
         next_tdo_oe_n = !(state == st_shift_ir || state == st_shift_dr);
         if (state == st_shift_ir) begin
            next_tdo = ir_sh[0];
         end else if (ir == IR_IDCODE) begin
            next_tdo = id_sh[0];
         end else if (bsr_sel) begin
            next_tdo = bsr_sh[0];
         end else begin
            next_tdo = byp;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_tdo <= 1'b0;
         o_tdo_oe_n <= 1'b1;
      end else begin
         o_tdo <= next_tdo;
         o_tdo_oe_n <= next_tdo_oe_n;
      end
   end

endmodule : boundary_scan_test_port
`default_nettype wire

/* File: tap_port_checker.sv */
// assertions on the boundary-scan test port pins
`timescale 1ns/1ns
`default_nettype none
module tap_port_checker
   import tap_pkg::*;
(
   // clock, reset and test link
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_tck,
   input wire logic i_trst_n,
   // observed outputs
   input wire logic o_tdo,
   input wire logic o_tdo_oe_n,
   input wire logic [BSR_W-1:0] o_pins,
   input wire logic o_extest
);
   ////////////////////////////////////////////////////////////////
   // test-clock history, bit 0 newest; the pin is async so we look at a span
   logic [5:0] tck_h;
   logic [5:0] next_tck_h;
   always_comb begin
      next_tck_h = {tck_h[4:0], i_tck};
   end
   always_ff @(posedge i_clk) begin
      tck_h <= next_tck_h;
   end
   ////////////////////////////////////////////////////////////////
   // pin relations
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_tdo_on_fall: assert property ($changed(o_tdo) |-> !(&tck_h[3:1]))
      else $error("data out moved without a test-clock fall");
   a_oe_on_fall: assert property ($fell(o_tdo_oe_n) |-> !(&tck_h[3:1]))
      else $error("data out enabled away from a fall");
   a_oe_off_fall: assert property ($rose(o_tdo_oe_n) |-> !(&tck_h[3:1]))
      else $error("data out released away from a fall");
   a_pins_on_rise: assert property ($changed(o_pins) |-> |tck_h[4:1])
      else $error("boundary outputs moved without a rise");
   a_extest_on_rise: assert property ($rose(o_extest) |-> |tck_h[4:1])
      else $error("external test set without a rise");
   a_trst_forces: assert property (!i_trst_n [*5] |-> o_tdo_oe_n && !o_extest)
      else $error("test reset did not force the controller");
   a_quiet_no_tck: assert property (i_trst_n && tck_h == 6'h00 |->
      $stable(o_tdo) && $stable(o_tdo_oe_n) && $stable(o_pins))
      else $error("test logic moved with the test clock still");
   a_reset_quiet: assert property (disable iff (1'b0)
      i_sys_rst |=> o_tdo_oe_n && !o_extest && o_pins == '0)
      else $error("outputs not quiet after reset");
endmodule : tap_port_checker
`default_nettype wire

/* File: tap_tester.sv */
// tester model that drives the test link from the system clock
`timescale 1ns/1ns
`default_nettype none
module tap_tester (
   // timing reference
   input wire logic i_clk,
   // test link
   input wire logic i_tdo,
   input wire logic i_tdo_oe_n,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_trst_n
);
   // a released line has no pull-up, so it shows the inverse of the last bit
   wire logic seen = i_tdo_oe_n ? ~i_tdo : i_tdo;
   // test clock stands low between frames, data idles at pull-up level
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_trst_n = 1'b1;
   end
   // wait n system clocks, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // level on test reset, held five clocks with no test-clock activity
   task automatic trst(input logic v);
      o_trst_n = v;
      tick(5);
   endtask : trst
   // one test clock; pins change at the fall, data out read late in high phase
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      tick(4);
      o_tck = 1'b1;
      tick(3);
      tdo = seen;
      tick(1);
      o_tck = 1'b0;
   endtask : step
   // from idle: select, capture, shift n bits lsb first, update, idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic d;
      dout = '0;
      step(1'b1, 1'b1, d);
      if (ir) begin
         step(1'b1, 1'b1, d);
      end
      step(1'b0, 1'b1, d);
      step(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'b1, 1'b1, d);
      step(1'b0, 1'b1, d);
   endtask : scan
endmodule : tap_tester
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none
bind boundary_scan_test_port tap_port_checker tap_port_checker_i (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_trst_n(i_trst_n), .o_tdo(o_tdo),
   .o_tdo_oe_n(o_tdo_oe_n), .o_pins(o_pins), .o_extest(o_extest));
module testbench;
   import tap_pkg::*;
   logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe_n, extest, d;
   logic [BSR_W-1:0] pins_in, pins_out;
   logic [31:0] got;
   int fail_count = 0;
   int tests_run = 0;
   boundary_scan_test_port boundary_scan_test_port_i (.i_clk(clk), .i_sys_rst(rst),
      .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
      .o_tdo_oe_n(tdo_oe_n), .i_pins(pins_in), .o_pins(pins_out), .o_extest(extest));
   tap_tester tap_tester_i (.i_clk(clk), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n),
      .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // compare and verdict
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] act);
      tests_run++;
      if (act !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, act);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////
   // test reset held with the test clock still, then identity read
   task automatic t_reset_id();
      tap_tester_i.trst(1'b0);
      check("extest", 32'h0, {31'h0, extest});
      check("oe", 32'h1, {31'h0, tdo_oe_n});
      tap_tester_i.trst(1'b1);
      tap_tester_i.step(1'b0, 1'b1, d);
      tap_tester_i.scan(1'b0, ID_W, '0, got);
      check("idcode", IDCODE_VALUE, got);
   endtask : t_reset_id
   // instruction capture pattern and the one-bit bypass path
   task automatic t_bypass();
      tap_tester_i.scan(1'b1, IR_W, {28'h0, IR_BYPASS}, got);
      check("ir capture", {28'h0, IR_CAPTURE}, got);
      tap_tester_i.scan(1'b0, 2, 32'h3, got);
      check("bypass", 32'h2, got);
   endtask : t_bypass
   // boundary capture and update under external test
   task automatic t_extest();
      pins_in = 8'ha5;
      tap_tester_i.scan(1'b1, IR_W, {28'h0, IR_EXTEST}, got);
      check("extest", 32'h1, {31'h0, extest});
      tap_tester_i.scan(1'b0, BSR_W, 32'h3c, got);
      check("capture", 32'ha5, got);
      check("update", 32'h3c, {24'h0, pins_out});
      check("oe", 32'h1, {31'h0, tdo_oe_n});
   endtask : t_extest
   // sample instruction: capture and update with external test dropped
   task automatic t_sample();
      pins_in = 8'h5a;
      tap_tester_i.scan(1'b1, IR_W, {28'h0, IR_SAMPLE}, got);
      check("ir capture", {28'h0, IR_CAPTURE}, got);
      check("extest", 32'h0, {31'h0, extest});
      tap_tester_i.scan(1'b0, BSR_W, 32'hc3, got);
      check("capture", 32'h5a, got);
      check("update", 32'hc3, {24'h0, pins_out});
   endtask : t_sample
   // main sequence; the second reset must also drop external test
   initial begin
      rst = 1'b1;
      pins_in = '0;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_reset_id();
      t_bypass();
      t_extest();
      t_sample();
      t_extest();
      t_reset_id();
      results();
   end
endmodule : testbench
`default_nettype wire
